// [pwc_pkg.sv]
// Constants, types and helper functions for the power controller start-up block.
// Assumes a 200 MHz core clock; only the start-up module uses these items, naming them as pwc_pkg::name.
package pwc_pkg;

  // Timing
  localparam int CLK_MHZ = 200;
  localparam int SHUT_TIME_US = 100;
  localparam int SHUT_CYC = SHUT_TIME_US * CLK_MHZ;

  // Register space: 32 writable bytes, then read-only feedback
  localparam int NREG = 32;
  localparam logic [5:0] REG_ALWAYS_ON = 6'h00;
  localparam logic [5:0] REG_GPIO_EN = 6'h01;
  localparam logic [5:0] REG_HOST_EN = 6'h02;
  localparam logic [5:0] REG_FREQ = 6'h03;
  localparam logic [5:0] REG_SYNC = 6'h04;
  localparam logic [5:0] REG_GPIO_MODE = 6'h05;
  localparam logic [5:0] REG_MISC = 6'h08;
  localparam logic [5:0] REG_CH_BASE = 6'h10;
  localparam logic [5:0] RO_FAULT = 6'h20;
  localparam logic [5:0] RO_MEAS = 6'h21;
  localparam logic [5:0] CMD_RESTART = 6'h3F;

  // Per-channel block: four bytes per channel from REG_CH_BASE
  localparam int CH_TARGET = 0;
  localparam int CH_DELAY = 1;
  localparam int CH_SLOPE = 2;
  localparam int CH_STOP = 3;

  // Fields of REG_MISC
  localparam int MISC_SERIAL_USE = 0;
  localparam int MISC_STBY_5V = 1;
  localparam int MISC_STBY_SRC = 2;
  localparam int MISC_STBY_GPIO = 4;
  localparam int MISC_STBY_HOST = 7;

  // Fault input bit positions
  localparam int FLT_OCP = 0;
  localparam int FLT_OVP = 1;
  localparam int FLT_TEMP = 2;

  // Modulator period is four times the frequency code in clock cycles
  localparam logic [7:0] FREQ_MIN = 8'h22;
  localparam logic [7:0] FREQ_MAX = 8'hA6;

  typedef enum logic [1:0] {
    SYNC_ALONE = 2'b00,
    SYNC_MASTER = 2'b01,
    SYNC_SLAVE = 2'b10
  } pwc_sync_t;

  typedef enum logic [1:0] {
    STBY_BY_ENABLE = 2'b00,
    STBY_BY_GPIO = 2'b01,
    STBY_BY_HOST = 2'b10
  } pwc_stby_t;

  typedef enum logic [2:0] {
    GM_INPUT = 3'b000,
    GM_OCP = 3'b001,
    GM_OVP = 3'b010,
    GM_TEMP = 3'b011,
    GM_SSTART = 3'b100,
    GM_PGOOD = 3'b101,
    GM_COMMON_EN = 3'b110
  } pwc_gmode_t;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_IDLE = 3'b001,
    ST_READY = 3'b010,
    ST_SHUT = 3'b011
  } pwc_mode_t;

  typedef enum logic [2:0] {
    CS_OFF = 3'b000,
    CS_DELAY = 3'b001,
    CS_RAMP = 3'b010,
    CS_ON = 3'b011,
    CS_STOP = 3'b100
  } pwc_chst_t;

  // Checksum byte update, polynomial x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    end
    return r;
  endfunction : crc8

endpackage : pwc_pkg

// [pwc_otp_store.sv]
// One-time-programmable configuration store with registered read data.
// Assumes programming strobes come from logic on the same clock.
`timescale 1ns/1ps
module pwc_otp_store #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock
  input wire logic clk_in,
  // Programming port
  input wire logic prog_en_in,
  input wire logic [AW-1:0] prog_addr_in,
  input wire logic [7:0] prog_data_in,
  // Read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);

  // Unprogrammed fuses read as zero
  logic [7:0] mem_q [DEPTH] = '{default: 8'h00};

  // Programming can only set bits, never clear them
  always_ff @(posedge clk_in) begin
    if (prog_en_in) begin
      mem_q[prog_addr_in] <= mem_q[prog_addr_in] | prog_data_in;
    end
    rd_data_out <= mem_q[rd_addr_in];
  end

  // Programmed bits stay programmed
  otp_keep_bits_a: assert property (@(posedge clk_in)
    prog_en_in |=> (mem_q[$past(prog_addr_in)] & $past(prog_data_in)) == $past(prog_data_in))
    else $error("programmed bit lost");

endmodule : pwc_otp_store

// [pwc_startup.sv]
// Start-up, configuration and channel enable logic of a four-channel buck controller.
// Assumes the serial bus engine and analog monitors run on clk_in; pins are synchronised here.
`timescale 1ns/1ps
module pwc_startup #(
  parameter int SD_CYC = pwc_pkg::SHUT_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Pins
  input wire logic enable_in,
  input wire logic sync_clk_in,
  input wire logic [5:0] gpio_in,
  output logic [5:0] gpio_out,
  output logic [5:0] gpio_oe_n_out,
  output logic sync_clk_out,
  // Monitors
  input wire logic [7:0] fault_in,
  input wire logic [31:0] meas_in,
  // Host commands from the serial engine
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [5:0] cmd_reg_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic cmd_pec_en_in,
  input wire logic [7:0] cmd_pec_in,
  output logic addr_ack_out,
  output logic rsp_valid_out,
  output logic rsp_err_out,
  output logic [7:0] rsp_data_out,
  output logic [7:0] rsp_pec_out,
  // Store programming
  input wire logic prog_en_in,
  input wire logic [4:0] prog_addr_in,
  input wire logic [7:0] prog_data_in,
  // Status and channel control
  output logic ready_out,
  output logic [3:0] ch_en_out,
  output logic [31:0] setpoint_out,
  output logic [3:0] phase_out,
  output logic stby_en_out,
  output logic stby_5v_out
);

  localparam int LCW = $clog2(SD_CYC + 1);

  typedef struct packed {
    pwc_pkg::pwc_mode_t fsm;
    logic en_s1;
    logic en_s2;
    logic [5:0] gp_s1;
    logic [5:0] gp_s2;
    logic sy_s1;
    logic sy_s2;
    logic sy_d;
    logic [LCW-1:0] low_cnt;
    logic [5:0] ld_cnt;
    logic ld_v;
    logic [4:0] ld_idx;
    logic [31:0][7:0] regs;
    logic [9:0] per;
    logic [3:0][2:0] cs;
    logic [3:0][7:0] dly;
    logic [3:0][7:0] sp;
    logic ready;
    logic [3:0] ch_en;
    logic [3:0] phase;
    logic sync_o;
    logic [5:0] gpo;
    logic [5:0] gpoe_n;
    logic stby_en;
    logic stby_5v;
    logic rsp_v;
    logic rsp_err;
    logic [7:0] rsp_d;
    logic [7:0] rsp_pec;
  } pwc_st_t;

  pwc_st_t q;
  pwc_st_t d;
  logic [7:0] otp_rdata;
  logic [7:0] code_w;
  logic tick_w;
  logic ce_any_w;
  logic [3:0] req_w;
  logic pec_bad_w;

  // Configuration store, read by the loader
  pwc_otp_store #(.DEPTH(pwc_pkg::NREG), .AW(5)) u_store (
    .clk_in(clk_in),
    .prog_en_in(prog_en_in),
    .prog_addr_in(prog_addr_in),
    .prog_data_in(prog_data_in),
    .rd_addr_in(q.ld_cnt[4:0]),
    .rd_data_out(otp_rdata)
  );

  // Next-state logic
  always_comb begin
    logic [7:0] mode_b;
    logic [2:0] gm;
    logic serial_pin;
    logic ce_lvl;
    logic sstart;
    logic pgood;
    logic anyon;
    logic [7:0] tgt;
    logic [7:0] slp;
    logic [7:0] stp;
    logic [7:0] rdat;
    logic [7:0] pec;
    logic [9:0] reload;
    logic restart;
    logic bad;
    mode_b = 8'h00;
    gm = 3'b000;
    serial_pin = 1'b0;
    ce_lvl = 1'b0;
    sstart = 1'b0;
    pgood = 1'b1;
    anyon = 1'b0;
    tgt = 8'h00;
    slp = 8'h00;
    stp = 8'h00;
    rdat = 8'h00;
    pec = 8'h00;
    restart = 1'b0;
    bad = 1'b0;
    reload = 10'h000;
    d = q;
    ce_any_w = 1'b0;
    req_w = 4'h0;
    pec_bad_w = 1'b0;

    // Pin synchronisers
    d.en_s1 = enable_in;
    d.en_s2 = q.en_s1;
    d.gp_s1 = gpio_in;
    d.gp_s2 = q.gp_s1;
    d.sy_s1 = sync_clk_in;
    d.sy_s2 = q.sy_s1;
    d.sy_d = q.sy_s2;

    // Frequency code held inside its legal range
    code_w = q.regs[pwc_pkg::REG_FREQ];
    if (code_w < pwc_pkg::FREQ_MIN) begin
      code_w = pwc_pkg::FREQ_MIN;
    end else if (code_w > pwc_pkg::FREQ_MAX) begin
      code_w = pwc_pkg::FREQ_MAX;
    end
    reload = {code_w, 2'b00} - 10'h001;

    // Modulator period counter; a slave restarts on the external edge
    tick_w = (q.per == 10'h000);
    if (q.regs[pwc_pkg::REG_SYNC][1:0] == pwc_pkg::SYNC_SLAVE && q.sy_s2 && !q.sy_d) begin
      d.per = reload;
    end else if (tick_w) begin
      d.per = reload;
    end else begin
      d.per = q.per - 10'h001;
    end
    for (int k = 0; k < 4; k++) begin
      d.phase[k] = (q.per == 10'(k * code_w));
    end
    d.sync_o = (q.regs[pwc_pkg::REG_SYNC][1:0] == pwc_pkg::SYNC_MASTER) &&
               (q.per < {1'b0, code_w, 1'b0});

    // Enable low-time counter
    if (q.en_s2) begin
      d.low_cnt = '0;
    end else if (q.low_cnt != LCW'(SD_CYC)) begin
      d.low_cnt = q.low_cnt + LCW'(1);
    end

    // Host command: read-only feedback and writable control
    if (q.fsm == pwc_pkg::ST_READY && cmd_valid_in) begin
      if (cmd_write_in) begin
        pec = pwc_pkg::crc8(pwc_pkg::crc8(8'h00, {2'b00, cmd_reg_in}), cmd_data_in);
        bad = cmd_pec_en_in && (pec != cmd_pec_in);
        pec_bad_w = bad;
        if (!bad && cmd_reg_in < 6'(pwc_pkg::NREG)) begin
          d.regs[cmd_reg_in[4:0]] = cmd_data_in;
        end else if (!bad && cmd_reg_in == pwc_pkg::CMD_RESTART) begin
          restart = 1'b1;
        end else begin
          bad = 1'b1;
        end
        d.rsp_d = 8'h00;
      end else begin
        if (cmd_reg_in < 6'(pwc_pkg::NREG)) begin
          rdat = q.regs[cmd_reg_in[4:0]];
        end else if (cmd_reg_in == pwc_pkg::RO_FAULT) begin
          rdat = fault_in;
        end else if (cmd_reg_in >= pwc_pkg::RO_MEAS && cmd_reg_in < pwc_pkg::RO_MEAS + 6'h04) begin
          rdat = meas_in[8 * (cmd_reg_in - pwc_pkg::RO_MEAS) +: 8];
        end else begin
          bad = 1'b1;
        end
        d.rsp_d = rdat;
      end
      d.rsp_pec = pwc_pkg::crc8(pwc_pkg::crc8(8'h00, {2'b00, cmd_reg_in}),
                                cmd_write_in ? cmd_data_in : rdat);
      d.rsp_v = 1'b1;
      d.rsp_err = bad;
    end else begin
      d.rsp_v = 1'b0;
      d.rsp_err = 1'b0;
    end

    // Start-up sequence
    case (q.fsm)
      pwc_pkg::ST_LOAD: begin
        if (q.ld_v) begin
          d.regs[q.ld_idx] = otp_rdata;
        end
        d.ld_v = 1'b0;
        if (q.ld_cnt < 6'(pwc_pkg::NREG)) begin
          d.ld_v = 1'b1;
          d.ld_idx = q.ld_cnt[4:0];
          d.ld_cnt = q.ld_cnt + 6'h01;
        end else if (!q.ld_v) begin
          d.fsm = pwc_pkg::ST_IDLE;
        end
      end
      pwc_pkg::ST_IDLE: begin
        if (q.en_s2) begin
          d.fsm = pwc_pkg::ST_READY;
        end else if (q.low_cnt == LCW'(SD_CYC)) begin
          d.fsm = pwc_pkg::ST_SHUT;
        end
      end
      pwc_pkg::ST_READY: begin
        if (q.low_cnt == LCW'(SD_CYC)) begin
          d.fsm = pwc_pkg::ST_SHUT;
        end
      end
      pwc_pkg::ST_SHUT: begin
        if (q.en_s2) begin
          restart = 1'b1;
        end
      end
      default: begin
        restart = 1'b1;
      end
    endcase
    if (restart) begin
      d.fsm = pwc_pkg::ST_LOAD;
      d.ld_cnt = 6'h00;
      d.ld_v = 1'b0;
    end

    // GPIO modes, common enable and shared serial pins
    for (int i = 0; i < 6; i++) begin
      mode_b = q.regs[int'(pwc_pkg::REG_GPIO_MODE) + i / 2];
      gm = (i % 2 == 1) ? mode_b[6:4] : mode_b[2:0];
      serial_pin = q.regs[pwc_pkg::REG_MISC][pwc_pkg::MISC_SERIAL_USE] && i >= 4;
      if (!serial_pin && gm == pwc_pkg::GM_COMMON_EN) begin
        ce_any_w = 1'b1;
        ce_lvl = ce_lvl | q.gp_s2[i];
      end
    end

    // Channel requests
    for (int k = 0; k < 4; k++) begin
      req_w[k] = q.regs[pwc_pkg::REG_ALWAYS_ON][k] |
                 (q.regs[pwc_pkg::REG_GPIO_EN][k] & q.gp_s2[k]) |
                 q.regs[pwc_pkg::REG_HOST_EN][k];
      if (ce_any_w) begin
        req_w[k] = ce_lvl;
      end
    end

    // Channel sequencers, each with its own delay, slope and stop level
    for (int k = 0; k < 4; k++) begin
      tgt = q.regs[int'(pwc_pkg::REG_CH_BASE) + 4 * k + pwc_pkg::CH_TARGET];
      slp = q.regs[int'(pwc_pkg::REG_CH_BASE) + 4 * k + pwc_pkg::CH_SLOPE];
      stp = q.regs[int'(pwc_pkg::REG_CH_BASE) + 4 * k + pwc_pkg::CH_STOP];
      if (stp > tgt) begin
        stp = tgt;
      end
      // Leaving READY by shutdown or restart drops channels on the same edge as ready
      if (q.fsm != pwc_pkg::ST_READY || d.fsm != pwc_pkg::ST_READY) begin
        d.cs[k] = pwc_pkg::CS_OFF;
        d.sp[k] = 8'h00;
      end else begin
        case (q.cs[k])
          pwc_pkg::CS_OFF: begin
            if (req_w[k]) begin
              d.cs[k] = pwc_pkg::CS_DELAY;
              d.dly[k] = q.regs[int'(pwc_pkg::REG_CH_BASE) + 4 * k + pwc_pkg::CH_DELAY];
            end
          end
          pwc_pkg::CS_DELAY: begin
            if (!req_w[k]) begin
              d.cs[k] = pwc_pkg::CS_STOP;
            end else if (tick_w && q.dly[k] == 8'h00) begin
              d.cs[k] = pwc_pkg::CS_RAMP;
            end else if (tick_w) begin
              d.dly[k] = q.dly[k] - 8'h01;
            end
          end
          pwc_pkg::CS_RAMP: begin
            if (!req_w[k]) begin
              d.cs[k] = pwc_pkg::CS_STOP;
            end else if (q.sp[k] >= tgt) begin
              d.sp[k] = tgt;
              d.cs[k] = pwc_pkg::CS_ON;
            end else if (tick_w) begin
              d.sp[k] = (tgt - q.sp[k] > slp) ? q.sp[k] + slp : tgt;
            end
          end
          pwc_pkg::CS_ON: begin
            d.sp[k] = tgt;
            if (!req_w[k]) begin
              d.cs[k] = pwc_pkg::CS_STOP;
            end
          end
          pwc_pkg::CS_STOP: begin
            if (q.sp[k] <= stp) begin
              d.sp[k] = 8'h00;
              d.cs[k] = pwc_pkg::CS_OFF;
            end else if (tick_w) begin
              d.sp[k] = (q.sp[k] - stp > slp) ? q.sp[k] - slp : stp;
            end
          end
          default: begin
            d.cs[k] = pwc_pkg::CS_OFF;
          end
        endcase
      end
      d.ch_en[k] = (d.cs[k] != pwc_pkg::CS_OFF);
      sstart = sstart | (q.cs[k] == pwc_pkg::CS_DELAY) | (q.cs[k] == pwc_pkg::CS_RAMP);
      pgood = pgood & (q.cs[k] == pwc_pkg::CS_ON || q.cs[k] == pwc_pkg::CS_OFF);
      anyon = anyon | (q.cs[k] == pwc_pkg::CS_ON);
    end

    // GPIO outputs; output enable low while driving
    for (int i = 0; i < 6; i++) begin
      mode_b = q.regs[int'(pwc_pkg::REG_GPIO_MODE) + i / 2];
      gm = (i % 2 == 1) ? mode_b[6:4] : mode_b[2:0];
      serial_pin = q.regs[pwc_pkg::REG_MISC][pwc_pkg::MISC_SERIAL_USE] && i >= 4;
      d.gpoe_n[i] = 1'b0;
      case (gm)
        pwc_pkg::GM_OCP: d.gpo[i] = fault_in[pwc_pkg::FLT_OCP];
        pwc_pkg::GM_OVP: d.gpo[i] = fault_in[pwc_pkg::FLT_OVP];
        pwc_pkg::GM_TEMP: d.gpo[i] = fault_in[pwc_pkg::FLT_TEMP];
        pwc_pkg::GM_SSTART: d.gpo[i] = sstart;
        pwc_pkg::GM_PGOOD: d.gpo[i] = pgood & anyon;
        default: begin
          d.gpo[i] = 1'b0;
          d.gpoe_n[i] = 1'b1;
        end
      endcase
      if (serial_pin) begin
        d.gpo[i] = 1'b0;
        d.gpoe_n[i] = 1'b1;
      end
    end

    // Standby regulator level and switch source
    mode_b = q.regs[pwc_pkg::REG_MISC];
    d.stby_5v = mode_b[pwc_pkg::MISC_STBY_5V];
    case (mode_b[pwc_pkg::MISC_STBY_SRC +: 2])
      pwc_pkg::STBY_BY_ENABLE: d.stby_en = q.en_s2;
      pwc_pkg::STBY_BY_GPIO: begin
        d.stby_en = 1'({2'b00, q.gp_s2} >> mode_b[pwc_pkg::MISC_STBY_GPIO +: 3]);
      end
      pwc_pkg::STBY_BY_HOST: d.stby_en = mode_b[pwc_pkg::MISC_STBY_HOST];
      default: d.stby_en = 1'b0;
    endcase

    d.ready = (d.fsm == pwc_pkg::ST_READY);
  end

  // State register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
      q.gpoe_n <= 6'h3F;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign ready_out = q.ready;
  assign addr_ack_out = q.ready;
  assign rsp_valid_out = q.rsp_v;
  assign rsp_err_out = q.rsp_err;
  assign rsp_data_out = q.rsp_d;
  assign rsp_pec_out = q.rsp_pec;
  assign ch_en_out = q.ch_en;
  assign setpoint_out = q.sp;
  assign phase_out = q.phase;
  assign sync_clk_out = q.sync_o;
  assign gpio_out = q.gpo;
  assign gpio_oe_n_out = q.gpoe_n;
  assign stby_en_out = q.stby_en;
  assign stby_5v_out = q.stby_5v;

  // Checks
  sequence rdy_rise_s;
    $rose(ready_out);
  endsequence

  no_ack_idle_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !ready_out |=> !rsp_valid_out && !addr_ack_out || ready_out)
    else $error("response while not ready");
  load_done_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    rdy_rise_s |-> q.ld_cnt == 6'(pwc_pkg::NREG) && !q.ld_v)
    else $error("ready before load finished");
  always_on_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    rdy_rise_s ##0 (q.regs[pwc_pkg::REG_ALWAYS_ON][0] && !ce_any_w) |=> ch_en_out[0])
    else $error("always-on channel not started");
  gpio_start_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    rdy_rise_s ##0 (q.regs[pwc_pkg::REG_GPIO_EN][1] && q.gp_s2[1] && !ce_any_w)
    |=> ch_en_out[1])
    else $error("gpio channel not started");
  chan_ready_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ch_en_out != 4'h0 |-> ready_out)
    else $error("channel on while not ready");
  shut_long_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (q.low_cnt == LCW'(SD_CYC) && !q.en_s2) |=> !ready_out)
    else $error("no shutdown after long enable low");
  stop_level_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (q.cs[0] == pwc_pkg::CS_STOP && tick_w) |=> q.sp[0] <= $past(q.sp[0]))
    else $error("soft-stop setpoint rose");
  phase_step_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    phase_out[1] |-> $past(q.per) == {2'b00, $past(code_w)})
    else $error("phase strobe off quarter period");
  freq_range_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    code_w >= pwc_pkg::FREQ_MIN && code_w <= pwc_pkg::FREQ_MAX)
    else $error("frequency code out of range");
  pec_reject_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    pec_bad_w |=> rsp_valid_out && rsp_err_out)
    else $error("bad checksum accepted");
  stby_pin_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    q.regs[pwc_pkg::REG_MISC][3:2] == pwc_pkg::STBY_BY_ENABLE |=> stby_en_out == $past(q.en_s2))
    else $error("standby switch not following enable");

endmodule : pwc_startup

// [pwc_host_model.sv]
// Host controller model driving the command port of the start-up block.
// Assumes answers are registered on the taking edge of clk_in.
`timescale 1ns/1ps
module pwc_host_model (
  // Clock
  input wire logic clk_in,
  // Commands
  output logic cmd_valid_out,
  output logic cmd_write_out,
  output logic [5:0] cmd_reg_out,
  output logic [7:0] cmd_data_out,
  output logic cmd_pec_en_out,
  output logic [7:0] cmd_pec_out,
  // Answers
  input wire logic rsp_valid_in,
  input wire logic rsp_err_in,
  input wire logic [7:0] rsp_data_in,
  input wire logic [7:0] rsp_pec_in
);
  // Checksum step, polynomial 07
  function automatic logic [7:0] sum8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    return r;
  endfunction : sum8

  // Idle command lines
  initial begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_reg_out = 6'h00;
    cmd_data_out = 8'h00;
    cmd_pec_en_out = 1'b0;
    cmd_pec_out = 8'h00;
  end

  // One command held for one edge, then a bounded wait for the answer
  task automatic xfer(input logic wr, input logic [5:0] rg, input logic [7:0] dt,
    input logic bad, output logic ok, output logic er, output logic [7:0] rd,
    output logic pok);
    logic [7:0] c;
    c = sum8(8'h00, {2'h0, rg});
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_write_out <= wr;
    cmd_reg_out <= rg;
    cmd_data_out <= dt;
    cmd_pec_en_out <= wr;
    cmd_pec_out <= bad ? ~sum8(c, dt) : sum8(c, dt);
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_reg_out <= ~rg;
    cmd_data_out <= ~dt;
    ok = 1'b0;
    for (int i = 0; i < 3 && !ok; i++) begin
      @(negedge clk_in);
      ok = rsp_valid_in === 1'b1;
    end
    er = rsp_err_in;
    rd = rsp_data_in;
    pok = rsp_pec_in === sum8(c, wr ? dt : rsp_data_in);
  endtask : xfer
endmodule : pwc_host_model

// [pwc_startup_tb_top.sv]
// Testbench: store programming, start-up, host commands, phases and shutdown.
// Assumes the host model file; the shutdown count is shortened to 50 cycles.
`timescale 1ns/1ps
module pwc_startup_tb_top;
  localparam int SD = 50;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic enable_in = 1'b0;
  logic sync_clk_in = 1'b0;
  logic [5:0] gpio_in = 6'h02;
  logic [7:0] fault_in = 8'h05;
  logic [31:0] meas_in = 32'h44332211;
  logic prog_en_in = 1'b0;
  logic [4:0] prog_addr_in = 5'h00;
  logic [7:0] prog_data_in = 8'h00;
  logic cmd_valid, cmd_write, cmd_pec_en, addr_ack, rsp_valid, rsp_err;
  logic ready, stby_en, stby_5v, sync_out, ok, er, pok;
  logic [5:0] cmd_reg, gpio_out, gpio_oe_n;
  logic [7:0] cmd_data, cmd_pec, rsp_data, rsp_pec, rd;
  logic [3:0] ch_en, phase;
  logic [31:0] setpoint;
  int failures = 0;
  int checked = 0;
  int n;

  // Core clock 200 MHz, sync clock 160 ns
  always #2.5 clk_in = ~clk_in;
  always #80 sync_clk_in = ~sync_clk_in;

  pwc_startup #(.SD_CYC(SD)) i_pwc_startup (.clk_in(clk_in), .rstn_in(rstn_in),
    .enable_in(enable_in), .sync_clk_in(sync_clk_in), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe_n_out(gpio_oe_n), .sync_clk_out(sync_out),
    .fault_in(fault_in), .meas_in(meas_in), .cmd_valid_in(cmd_valid),
    .cmd_write_in(cmd_write), .cmd_reg_in(cmd_reg), .cmd_data_in(cmd_data),
    .cmd_pec_en_in(cmd_pec_en), .cmd_pec_in(cmd_pec), .addr_ack_out(addr_ack),
    .rsp_valid_out(rsp_valid), .rsp_err_out(rsp_err), .rsp_data_out(rsp_data),
    .rsp_pec_out(rsp_pec), .prog_en_in(prog_en_in), .prog_addr_in(prog_addr_in),
    .prog_data_in(prog_data_in), .ready_out(ready), .ch_en_out(ch_en),
    .setpoint_out(setpoint), .phase_out(phase), .stby_en_out(stby_en),
    .stby_5v_out(stby_5v));

  pwc_host_model i_pwc_host_model (.clk_in(clk_in), .cmd_valid_out(cmd_valid),
    .cmd_write_out(cmd_write), .cmd_reg_out(cmd_reg), .cmd_data_out(cmd_data),
    .cmd_pec_en_out(cmd_pec_en), .cmd_pec_out(cmd_pec), .rsp_valid_in(rsp_valid),
    .rsp_err_in(rsp_err), .rsp_data_in(rsp_data), .rsp_pec_in(rsp_pec));

  // Verdict and end of run
  task automatic complete_run();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Bounded wait for a ready level
  task automatic wait_rdy(input logic e);
    n = 0;
    while (ready !== e && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    if (ready !== e) begin
      failures++;
      complete_run();
    end
  endtask : wait_rdy

  // Bounded wait for a phase pulse, cycles waited in n
  task automatic gap(input int k);
    n = 0;
    while (phase[k] !== 1'b1 && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    if (phase[k] !== 1'b1) begin
      failures++;
      complete_run();
    end
  endtask : gap

  // Store programming pulse
  task automatic prog(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_in);
    prog_en_in <= 1'b1;
    prog_addr_in <= a;
    prog_data_in <= d;
    @(posedge clk_in);
    prog_en_in <= 1'b0;
  endtask : prog

  // Host command with its expected answer
  task automatic cmd(input logic wr, input logic [5:0] rg, input logic [7:0] dt,
    input logic bad, input logic eer, input logic [7:0] erd);
    i_pwc_host_model.xfer(wr, rg, dt, bad, ok, er, rd, pok);
    chk("answer", 1'b1, ok);
    chk("error", eer, er);
    if (!eer) chk("checksum", 1'b1, pok);
    if (!wr && !eer) chk("read data", erd, rd);
  endtask : cmd

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_in);
    chk("reset ready", 1'b0, ready);
    chk("reset oe", 6'h3F, gpio_oe_n);
    rstn_in <= 1'b1;
    repeat (40) @(posedge clk_in);
    prog(5'h00, 8'h01);
    prog(5'h01, 8'h02);
    prog(5'h00, 8'h00);
    i_pwc_host_model.xfer(1'b0, 6'h00, 8'h00, 1'b0, ok, er, rd, pok);
    chk("early answer", 1'b0, ok);
    chk("early ack", 1'b0, addr_ack);
    @(posedge clk_in);
    enable_in <= 1'b1;
    wait_rdy(1'b1);
    chk("ack", 1'b1, addr_ack);
    cmd(1'b1, 6'h3F, 8'h00, 1'b0, 1'b0, 8'h00);
    chk("restart ready", 1'b0, ready);
    wait_rdy(1'b1);
    repeat (3) @(negedge clk_in);
    chk("start channels", 4'h3, ch_en);
    cmd(1'b0, 6'h00, 8'h00, 1'b0, 1'b0, 8'h01);
    // Channel 2: target 04, slope 02, stop level 00
    cmd(1'b1, 6'h18, 8'h04, 1'b0, 1'b0, 8'h00);
    cmd(1'b1, 6'h1A, 8'h02, 1'b0, 1'b0, 8'h00);
    cmd(1'b1, 6'h02, 8'h04, 1'b0, 1'b0, 8'h00);
    repeat (2) @(negedge clk_in);
    chk("host channel", 4'h7, ch_en);
    cmd(1'b1, 6'h03, 8'h10, 1'b0, 1'b0, 8'h00);
    cmd(1'b0, 6'h03, 8'h00, 1'b0, 1'b0, 8'h10);
    cmd(1'b1, 6'h04, 8'h01, 1'b0, 1'b0, 8'h00);
    cmd(1'b1, 6'h05, 8'h51, 1'b0, 1'b0, 8'h00);
    cmd(1'b1, 6'h08, 8'h8A, 1'b0, 1'b0, 8'h00);
    repeat (3) @(negedge clk_in);
    chk("fault pin", 2'b01, {gpio_oe_n[0], gpio_out[0]});
    chk("standby", 2'b11, {stby_en, stby_5v});
    cmd(1'b1, 6'h01, 8'h00, 1'b1, 1'b1, 8'h00);
    cmd(1'b0, 6'h01, 8'h00, 1'b0, 1'b0, 8'h02);
    cmd(1'b1, 6'h20, 8'h00, 1'b0, 1'b1, 8'h00);
    cmd(1'b0, 6'h20, 8'h00, 1'b0, 1'b0, 8'h05);
    cmd(1'b0, 6'h21, 8'h00, 1'b0, 1'b0, 8'h11);
    cmd(1'b0, 6'h30, 8'h00, 1'b0, 1'b1, 8'h00);
    // Counter runs down, so phase 3 leads, then 2, 1 and 0, a quarter period apart
    gap(3);
    gap(2);
    chk("phase 2 gap", 32'd34, n);
    chk("sync low", 1'b0, sync_out);
    gap(1);
    chk("phase 1 gap", 32'd34, n);
    chk("sync high", 1'b1, sync_out);
    repeat (450) @(negedge clk_in);
    chk("ramped setpoint", 32'h00040000, setpoint);
    chk("power good pin", 2'b01, {gpio_oe_n[1], gpio_out[1]});
    cmd(1'b1, 6'h02, 8'h00, 1'b0, 1'b0, 8'h00);
    repeat (300) @(negedge clk_in);
    chk("soft-stop setpoint", 32'h00000000, setpoint);
    chk("stopped channel", 4'h3, ch_en);
    @(posedge clk_in);
    enable_in <= 1'b0;
    repeat (SD - 10) @(negedge clk_in);
    chk("ready held", 1'b1, ready);
    wait_rdy(1'b0);
    chk("shutdown time", 32'd14, n);
    chk("channels off", 4'h0, ch_en);
    complete_run();
  end
endmodule : pwc_startup_tb_top
